// File: lsw_top.sv
// limit switch output block with ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module lsw_top import lsw_pkg::*; #(
    parameter int NSET = 64,
    parameter int NWATCH = 16,
    parameter int TICK_CYCLES = OP_CYCLE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // controller ready flag pin and watch words
    input wire logic controller_ready_flag_i,
    input wire logic [NWATCH*32-1:0] watch_data_i,
    // results
    output logic ready_complete_flag_o,
    output logic [NPT-1:0] point_out_o
);
    localparam int SW = $clog2(NSET);

    // bus state
    logic wr_pend_reg, rd_pend_reg, hready_reg, hresp_reg;
    logic [11:0] addr_reg;
    logic [31:0] hrdata_reg;
    // control state
    logic [31:0] ctrl_reg, comp_reg;
    logic [NPT-1:0] pt_reg [NPTREG];
    logic [31:0] cfg_reg [NSET];
    logic [31:0] lim_reg [NSET*NLIM];
    logic [31:0] lat_reg [NSET*NLIM];
    logic [NPT-1:0] out_reg, out_next;
    logic ready_meta_reg, ready_sync_reg, ready_last_reg, ready_cmp_reg;
    logic eval_reg;
    logic tick;

    // bus decode
    logic ap, wr_ctrl, wr_comp, wr_pt, wr_set, pt_half;
    logic [3:0] pt_idx;
    logic [2:0] pt_k;
    logic [SW-1:0] set_idx;
    logic [2:0] set_fld;
    logic in_set;
    logic [31:0] rd_mux, set_rd, pt_rd;
    logic signed [31:0] comp_wr;
    assign ap = hsel_i & htrans_i[HTRANS_ACT_BIT] & hready_i;
    assign in_set = addr_reg[11] && ({1'b0, addr_reg[10:SET_LSB]} < 7'(NSET));
    assign set_idx = addr_reg[SET_LSB +: SW];
    assign set_fld = addr_reg[4:2];
    assign pt_idx = addr_reg[5:2] - 4'(OFF_PT_BASE >> 2);
    assign pt_k = pt_idx[3:1];
    assign pt_half = pt_idx[0];
    assign wr_ctrl = wr_pend_reg && (addr_reg == OFF_CTRL);
    assign wr_comp = wr_pend_reg && (addr_reg == OFF_COMP);
    assign wr_pt = wr_pend_reg && (addr_reg >= OFF_PT_BASE) && (addr_reg < OFF_OUT_L);
    assign wr_set = wr_pend_reg && in_set && (set_fld <= 3'(NLIM));
    assign comp_wr = hwdata_i;

    // ready flag synchroniser and edges
    logic rdy_rise, rdy_fall;
    assign rdy_rise = ready_sync_reg & ~ready_last_reg;
    assign rdy_fall = ~ready_sync_reg & ready_last_reg;

    lsw_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    // bus protocol: writes zero-wait, reads one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            hready_reg <= 1'b1;
            hresp_reg <= 1'b0;
            addr_reg <= 12'h000;
            hrdata_reg <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= ap & hwrite_i;
            rd_pend_reg <= ap & ~hwrite_i;
            if (ap) begin
                addr_reg <= {haddr_i[11:2], 2'b00};
            end
            hready_reg <= ~(ap & ~hwrite_i);
            if (rd_pend_reg) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // read selection
    assign set_rd = (set_fld == 3'h0) ? cfg_reg[set_idx] :
                    (set_fld <= 3'(NLIM)) ? lim_reg[{set_idx, 2'(set_fld - 3'h1)}] : 32'h0000_0000;
    assign pt_rd = pt_half ? pt_reg[pt_k][63:32] : pt_reg[pt_k][31:0];
    assign rd_mux = in_set ? set_rd :
                    (addr_reg == OFF_CTRL) ? ctrl_reg :
                    (addr_reg == OFF_STATUS) ? {30'h0, ready_sync_reg, ready_cmp_reg} :
                    (addr_reg == OFF_COMP) ? comp_reg :
                    (addr_reg >= OFF_PT_BASE && addr_reg < OFF_OUT_L) ? pt_rd :
                    (addr_reg == OFF_OUT_L) ? out_reg[31:0] :
                    (addr_reg == OFF_OUT_H) ? out_reg[63:32] : 32'h0000_0000;

    // global control and clamped compensation value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
            comp_reg <= COMP_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= hwdata_i;
            end
            if (wr_comp) begin
                comp_reg <= (comp_wr > COMP_MAX_US) ? COMP_MAX_US :
                            (comp_wr < COMP_MIN_US) ? COMP_MIN_US : comp_wr;
            end
        end
    end

    // per-point masks: forced off en/bit, forced on en/bit, relay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < NPTREG; k++) begin
                pt_reg[k] <= PT_RST;
            end
        end else if (wr_pt) begin
            if (pt_half) begin
                pt_reg[pt_k][63:32] <= hwdata_i;
            end else begin
                pt_reg[pt_k][31:0] <= hwdata_i;
            end
        end
    end

    // setting configuration and limit sources
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int s = 0; s < NSET; s++) begin
                cfg_reg[s] <= CFG_RST;
            end
        end else if (wr_set && set_fld == 3'h0) begin
            cfg_reg[set_idx] <= hwdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NSET*NLIM; i++) begin
                lim_reg[i] <= LIM_RST;
            end
        end else if (wr_set && set_fld != 3'h0) begin
            lim_reg[{set_idx, 2'(set_fld - 3'h1)}] <= hwdata_i;
        end
    end

    // internal limit copy: capture on ready rise, refresh each tick while ready-complete
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NSET*NLIM; i++) begin
                lat_reg[i] <= LIM_RST;
            end
        end else if (rdy_rise || (tick && ready_cmp_reg)) begin
            for (int i = 0; i < NSET*NLIM; i++) begin
                lat_reg[i] <= lim_reg[i];
            end
        end
    end

    // ready tracking and evaluation strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_meta_reg <= 1'b0;
            ready_sync_reg <= 1'b0;
            ready_last_reg <= 1'b0;
            ready_cmp_reg <= 1'b0;
            eval_reg <= 1'b0;
        end else begin
            ready_meta_reg <= controller_ready_flag_i;
            ready_sync_reg <= ready_meta_reg;
            ready_last_reg <= ready_sync_reg;
            ready_cmp_reg <= rdy_rise ? 1'b1 : rdy_fall ? 1'b0 : ready_cmp_reg;
            eval_reg <= tick & ready_cmp_reg & ~rdy_fall;
        end
    end

    // region evaluation per setting
    logic [NSET-1:0] set_hit;
    logic [NSET-1:0] set_en;
    logic [PT_W-1:0] set_tgt [NSET];
    genvar gs;
    generate
        for (gs = 0; gs < NSET; gs++) begin : g_set
            logic [31:0] lim_eff [NLIM];
            logic [31:0] val;
            logic [CFG_WSEL_W-1:0] wsel;
            logic act1, act2;
            assign wsel = cfg_reg[gs][CFG_WSEL_LSB +: CFG_WSEL_W];
            assign val = (int'(wsel) < NWATCH) ? watch_data_i[wsel*32 +: 32] : 32'h0000_0000;
            for (genvar gl = 0; gl < NLIM; gl++) begin : g_lim
                assign lim_eff[gl] = cfg_reg[gs][CFG_WSRC_BIT] ? lat_reg[gs*NLIM+gl] : lim_reg[gs*NLIM+gl];
            end
            lsw_region u_reg1 (
                .lo_i(lim_eff[0]),
                .hi_i(lim_eff[1]),
                .val_i(val),
                .narrow_i(cfg_reg[gs][CFG_N16_BIT]),
                .act_o(act1)
            );
            lsw_region u_reg2 (
                .lo_i(lim_eff[2]),
                .hi_i(lim_eff[3]),
                .val_i(val),
                .narrow_i(cfg_reg[gs][CFG_N16_BIT]),
                .act_o(act2)
            );
            assign set_en[gs] = cfg_reg[gs][CFG_EN_BIT];
            assign set_hit[gs] = set_en[gs] & (act1 | act2);
            assign set_tgt[gs] = cfg_reg[gs][CFG_TGT_LSB +: PT_W];
        end
    endgenerate

    // gather settings onto points
    logic [NPT-1:0] pt_hit, pt_asg, batch_mask, f_off, f_on, eval_val, drop_val;
    always_comb begin
        pt_hit = '0;
        pt_asg = '0;
        for (int s = 0; s < NSET; s++) begin
            if (set_en[s]) begin
                pt_hit[set_tgt[s]] = pt_hit[set_tgt[s]] | set_hit[s];
                pt_asg[set_tgt[s]] = 1'b1;
            end
        end
    end
    genvar gg;
    generate
        for (gg = 0; gg < NGRP; gg++) begin : g_grp
            assign batch_mask[gg*GRP_PTS +: GRP_PTS] = {GRP_PTS{ctrl_reg[CTRL_BATCH_LSB+gg]}};
        end
    endgenerate
    assign f_off = pt_reg[0] & pt_reg[1];
    assign f_on = pt_reg[2] & pt_reg[3];
    assign eval_val = ((pt_hit | (out_reg & ~pt_asg & ~batch_mask)) & ~f_off) | f_on;
    assign drop_val = ctrl_reg[CTRL_HOLD_BIT] ? (out_reg & ~pt_reg[4]) : '0;
    assign out_next = rdy_fall ? drop_val : eval_reg ? eval_val : out_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_reg <= PT_RST;
        end else begin
            out_reg <= out_next;
        end
    end

    assign hrdata_o = hrdata_reg;
    assign hreadyout_o = hready_reg;
    assign hresp_o = hresp_reg;
    assign ready_complete_flag_o = ready_cmp_reg;
    assign point_out_o = out_reg;

    // checks
    logic fell_q;
    assign fell_q = ready_last_reg & ~ready_sync_reg;
    AST_READY_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
        rdy_rise |=> ready_cmp_reg ##1 (ready_cmp_reg || !ready_last_reg))
        else $error("ready-complete did not follow the ready rise");
    AST_DROP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        (fell_q && !ctrl_reg[CTRL_HOLD_BIT]) |=> (out_reg == '0))
        else $error("outputs not cleared on ready drop");
    AST_RELAY_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        fell_q |=> ((out_reg & $past(pt_reg[4])) == '0))
        else $error("relay point kept on after ready drop");
    AST_HOLD_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        (fell_q && ctrl_reg[CTRL_HOLD_BIT]) |=> ((out_reg & ~$past(pt_reg[4])) == ($past(out_reg) & ~$past(pt_reg[4]))))
        else $error("non-relay point changed under hold");
    AST_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        rdy_rise |=> (lat_reg[0] == $past(lim_reg[0])))
        else $error("limits not captured on ready rise");
    AST_REFRESH: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && ready_cmp_reg) |=> (lat_reg[NSET*NLIM-1] == $past(lim_reg[NSET*NLIM-1])))
        else $error("limits not refreshed on tick");
    AST_FORCE_ON: assert property (@(posedge clk_i) disable iff (rst_i)
        (eval_reg && !rdy_fall) |=> ((out_reg & $past(f_on)) == $past(f_on)))
        else $error("forced-on point not driven on");
    AST_FORCE_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        (eval_reg && !rdy_fall) |=> ((out_reg & $past(f_off) & ~$past(f_on)) == '0))
        else $error("forced-off point not driven off");
    AST_TICK_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        (!eval_reg && !rdy_fall) |=> $stable(out_reg))
        else $error("outputs changed outside an evaluation");
    AST_BATCH_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        (eval_reg && !rdy_fall) |=> ((out_reg & $past(batch_mask & ~pt_asg & ~f_on)) == '0))
        else $error("unassigned batch point not off");
    AST_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i)
        ($signed(comp_reg) <= COMP_MAX_US) && ($signed(comp_reg) >= COMP_MIN_US))
        else $error("compensation value out of range");
    AST_EVAL_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
        eval_reg |-> $past(ready_cmp_reg))
        else $error("evaluation without ready-complete");
    AST_NO_EVAL_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
        !ready_cmp_reg |=> !eval_reg)
        else $error("evaluation strobe while ready-complete is low");
    AST_READY_FALL: assert property (@(posedge clk_i) disable iff (rst_i)
        rdy_fall |=> !ready_cmp_reg)
        else $error("ready-complete kept after ready drop");
    AST_OR_POINTS: assert property (@(posedge clk_i) disable iff (rst_i)
        (eval_reg && !rdy_fall) |=> ((out_reg & $past(pt_hit & ~f_off)) == $past(pt_hit & ~f_off)))
        else $error("hit point not driven on");
    AST_ASG_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        (eval_reg && !rdy_fall) |=> ((out_reg & $past(pt_asg & ~pt_hit & ~f_on)) == '0))
        else $error("assigned point without hit not off");
    AST_UNASG_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (eval_reg && !rdy_fall) |=> ((out_reg & $past(~pt_asg & ~batch_mask & ~f_off & ~f_on)) == ($past(out_reg) & $past(~pt_asg & ~batch_mask & ~f_off & ~f_on))))
        else $error("unassigned point outside batch changed");
    AST_TICK_EVAL: assert property (@(posedge clk_i) disable iff (rst_i)
        (tick && ready_cmp_reg && !rdy_fall) |=> eval_reg)
        else $error("tick while ready gave no evaluation");
    AST_STATIC_LAT: assert property (@(posedge clk_i) disable iff (rst_i)
        !(rdy_rise || (tick && ready_cmp_reg)) |=> (lat_reg[0] == $past(lat_reg[0])))
        else $error("limit copy changed outside capture");
    AST_COMP_HI: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_comp && ($signed(hwdata_i) > COMP_MAX_US)) |=> (comp_reg == COMP_MAX_US))
        else $error("high compensation value not clamped");
    AST_COMP_LO: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_comp && ($signed(hwdata_i) < COMP_MIN_US)) |=> (comp_reg == COMP_MIN_US))
        else $error("low compensation value not clamped");
    COV_RISE: cover property (@(posedge clk_i) disable iff (rst_i) rdy_rise ##[1:100] eval_reg);
    COV_HOLD: cover property (@(posedge clk_i) disable iff (rst_i) fell_q && ctrl_reg[CTRL_HOLD_BIT]);
    COV_FON: cover property (@(posedge clk_i) disable iff (rst_i) eval_reg && (f_on & f_off) != '0);
    COV_HIT: cover property (@(posedge clk_i) disable iff (rst_i) eval_reg && pt_hit != '0);
    COV_BATCH: cover property (@(posedge clk_i) disable iff (rst_i) eval_reg && (batch_mask & ~pt_asg) != '0);
endmodule // lsw_top

// File: lsw_pkg.sv
// shared constants for the limit switch window compare block
// Overview of operation
// - every setting owns two independent on regions, each a lower/upper pair
// - lower, upper and watch value compare as signed two's-complement numbers
// - lower below upper: on when value at least lower and below upper
// - lower above upper: on when value at least lower or below upper
// - equal lower and upper: that region is never on
// - outputs evaluate only while ready-complete, which follows a rising ready flag
// - hold enabled: non-relay points keep their state; one global setting
// - relay points always go off when the ready flag falls
// - word-sourced limits are captured when the ready flag rises
// - word-sourced limits refresh once per operation cycle, outputs use them
// - up to 64 settings; settings may share watch values and targets
// - a point is the OR of both regions of every enabled setting targeting it
// - enabled forced-off with its bit set drives the point off; default disabled
// - enabled forced-on with its bit set drives on, beating forced-off and regions
// - with batch output on, unassigned points of a 16-point group stay off
// - compensation value clamps to plus or minus 5000000 microseconds
package lsw_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OP_CYCLE_US = 444;
    localparam int OP_CYCLE_CYCLES = (OP_CYCLE_US * 1000) / CLK_PERIOD_NS;
    localparam int NPT = 64;
    localparam int PT_W = 6;
    localparam int GRP_PTS = 16;
    localparam int NGRP = 4;
    localparam int NLIM = 4;
    localparam int NPTREG = 5;
    localparam int SET_LSB = 5;
    localparam int HTRANS_ACT_BIT = 1;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_COMP = 12'h008;
    localparam logic [11:0] OFF_PT_BASE = 12'h010;
    localparam logic [11:0] OFF_OUT_L = 12'h038;
    localparam logic [11:0] OFF_OUT_H = 12'h03c;
    localparam logic [11:0] OFF_SET_BASE = 12'h800;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_BATCH_LSB = 4;
    localparam int STAT_RDY_BIT = 0;
    localparam int STAT_SYNC_BIT = 1;
    localparam int CFG_TGT_LSB = 0;
    localparam int CFG_WSEL_LSB = 8;
    localparam int CFG_WSEL_W = 4;
    localparam int CFG_EN_BIT = 16;
    localparam int CFG_N16_BIT = 17;
    localparam int CFG_WSRC_BIT = 18;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] LIM_RST = 32'h0000_0000;
    localparam logic [31:0] COMP_RST = 32'h0000_0000;
    localparam logic [NPT-1:0] PT_RST = 64'h0000_0000_0000_0000;
    localparam logic signed [31:0] COMP_MAX_US = 32'sh004c_4b40;
    localparam logic signed [31:0] COMP_MIN_US = 32'shffb3_b4c0;
endpackage

// File: lsw_region.sv
// one signed on-region comparator
`timescale 1ns/10ps
module lsw_region import lsw_pkg::*; (
    // limits and value
    input wire logic [31:0] lo_i,
    input wire logic [31:0] hi_i,
    input wire logic [31:0] val_i,
    input wire logic narrow_i,
    // result
    output logic act_o
);
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    logic signed [31:0] val;
    assign lo = narrow_i ? {{16{lo_i[15]}}, lo_i[15:0]} : lo_i;
    assign hi = narrow_i ? {{16{hi_i[15]}}, hi_i[15:0]} : hi_i;
    assign val = narrow_i ? {{16{val_i[15]}}, val_i[15:0]} : val_i;
    assign act_o = (lo < hi) ? ((val >= lo) && (val < hi)) :
                   (lo > hi) ? ((val >= lo) || (val < hi)) :
                   1'b0;
endmodule // lsw_region

// File: lsw_tick.sv
// operation cycle tick divider
`timescale 1ns/10ps
module lsw_tick #(
    parameter int CYCLES = 88800
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // tick pulse
    output logic tick_o
);
    logic [31:0] cnt_reg;
    logic tick_reg;
    logic wrap;
    assign wrap = (cnt_reg == 32'(CYCLES - 1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
            tick_reg <= wrap;
        end
    end
    assign tick_o = tick_reg;
endmodule // lsw_tick

// File: lsw_bench.sv
// self-checking bench for the limit switch window compare block
`timescale 1ns/10ps
module lsw_bench import lsw_pkg::*;;
    localparam int TK = 20;
    typedef struct {
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] val;
        logic nar;
        logic exp;
    } lsw_row_t;
    // limits, watch value, 16-bit flag, expected point 0
    lsw_row_t rows [10] = '{
        '{32'h0000_000a, 32'h0000_0014, 32'h0000_000a, 1'b0, 1'b1},
        '{32'h0000_000a, 32'h0000_0014, 32'h0000_0014, 1'b0, 1'b0},
        '{32'h0000_000a, 32'h0000_0014, 32'h0000_0009, 1'b0, 1'b0},
        '{32'hffff_fff6, 32'h0000_000a, 32'hffff_fffb, 1'b0, 1'b1},
        '{32'hffff_fff6, 32'h0000_000a, 32'h8000_0000, 1'b0, 1'b0},
        '{32'h0000_0064, 32'hffff_ff9c, 32'h0000_00c8, 1'b0, 1'b1},
        '{32'h0000_0064, 32'hffff_ff9c, 32'hffff_ff38, 1'b0, 1'b1},
        '{32'h0000_0064, 32'hffff_ff9c, 32'h0000_0000, 1'b0, 1'b0},
        '{32'h0000_0005, 32'h0000_0005, 32'h0000_0005, 1'b0, 1'b0},
        '{32'h0000_0000, 32'h0000_0010, 32'hffff_0005, 1'b1, 1'b1}
    };
    logic clk;
    logic rst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hrdy;
    logic hresp;
    logic rdy_pin;
    logic [16*32-1:0] wd;
    logic rc;
    logic [NPT-1:0] pts;
    int err_count = 0;
    int num_checks = 0;

    lsw_top #(.NSET(64), .NWATCH(16), .TICK_CYCLES(TK)) i_dut (
        .clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .controller_ready_flag_i(rdy_pin), .watch_data_i(wd),
        .ready_complete_flag_o(rc), .point_out_o(pts)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chkw(input string n, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // one edge, then until the slave is ready
    task automatic wait_hrdy;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        haddr <= {20'h0_0000, a};
        hwrite <= 1'b1;
        htrans <= 2'b10;
        wait_hrdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_hrdy();
    endtask

    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        haddr <= {20'h0_0000, a};
        hwrite <= 1'b0;
        htrans <= 2'b10;
        wait_hrdy();
        htrans <= 2'b00;
        wait_hrdy();
        chkw(n, {32'h0, e}, {32'h0, hrdata});
    endtask

    function automatic logic [31:0] mk(input int t, input int w, input logic nar, input logic ws);
        return 32'(t) | (32'(w) << CFG_WSEL_LSB) | (32'h1 << CFG_EN_BIT)
            | (32'(nar) << CFG_N16_BIT) | (32'(ws) << CFG_WSRC_BIT);
    endfunction

    task automatic cfg(input int s, input logic [31:0] c, input logic [31:0] l1, input logic [31:0] h1,
                       input logic [31:0] l2, input logic [31:0] h2);
        logic [11:0] b;
        b = OFF_SET_BASE + 12'(s * 32);
        wr(b, c);
        wr(b + 12'h004, l1);
        wr(b + 12'h008, h1);
        wr(b + 12'h00c, l2);
        wr(b + 12'h010, h2);
    endtask

    // at least two operation ticks so an evaluation has landed
    task automatic settle;
        repeat (2 * TK + 4) @(posedge clk);
    endtask

    task automatic set_ready(input logic v);
        int n;
        rdy_pin <= v;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rc !== v && n < 10);
        @(posedge clk);
        chk1("ready complete", v, rc);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rdy_pin = 1'b0;
        wd = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk1("ready after reset", 1'b0, rc);
        chkw("points after reset", 64'h0, pts);
        rdchk("ctrl reset", OFF_CTRL, CTRL_RST);
        set_ready(1'b1);
        for (int i = 0; i < 10; i++) begin
            cfg(0, mk(0, 0, rows[i].nar, 1'b0), rows[i].lo, rows[i].hi, 32'h0, 32'h0);
            wd[31:0] <= rows[i].val;
            settle();
            chk1("row point 0", rows[i].exp, pts[0]);
        end
        cfg(0, mk(0, 0, 1'b0, 1'b0), 32'h0, 32'h0, 32'h0, 32'h64);
        wd[31:0] <= 32'h32;
        settle();
        chk1("second region", 1'b1, pts[0]);
        cfg(0, mk(0, 0, 1'b0, 1'b0), 32'h0, 32'h0, 32'h0, 32'h0);
        cfg(1, mk(0, 1, 1'b0, 1'b0), 32'h0, 32'h64, 32'h0, 32'h0);
        cfg(63, mk(63, 0, 1'b0, 1'b0), 32'h0, 32'h64, 32'h0, 32'h0);
        wd[63:32] <= 32'h32;
        settle();
        chk1("shared point", 1'b1, pts[0]);
        chk1("last setting", 1'b1, pts[63]);
        wr(12'h018, 32'h1);
        settle();
        chk1("off bit not enabled", 1'b1, pts[0]);
        wr(12'h010, 32'h1);
        settle();
        chk1("forced off", 1'b0, pts[0]);
        wr(12'h028, 32'h1);
        wr(12'h020, 32'h1);
        settle();
        chk1("forced on wins", 1'b1, pts[0]);
        wr(12'h020, 32'h0);
        wr(12'h010, 32'h0);
        wr(OFF_COMP, 32'h7fff_ffff);
        rdchk("comp high", OFF_COMP, COMP_MAX_US);
        wr(OFF_COMP, 32'h8000_0000);
        rdchk("comp low", OFF_COMP, COMP_MIN_US);
        wr(OFF_COMP, 32'h004c_4b3f);
        rdchk("comp inside", OFF_COMP, 32'h004c_4b3f);
        wr(12'h100, 32'hffff_ffff);
        rdchk("unmapped", 12'h100, 32'h0);
        chk1("response okay", 1'b0, hresp);
        cfg(2, mk(1, 2, 1'b0, 1'b1), 32'h0, 32'h64, 32'h0, 32'h0);
        wd[95:64] <= 32'h32;
        settle();
        chk1("word limits on", 1'b1, pts[1]);
        wr(12'h848, 32'ha);
        settle();
        chk1("word limits refreshed", 1'b0, pts[1]);
        wr(12'h848, 32'h64);
        cfg(3, mk(5, 0, 1'b0, 1'b0), 32'h0, 32'h64, 32'h0, 32'h0);
        settle();
        chk1("point 5 on", 1'b1, pts[5]);
        wr(12'h860, 32'h5);
        settle();
        chk1("unassigned holds", 1'b1, pts[5]);
        wr(OFF_CTRL, 32'h10);
        settle();
        chk1("batch clears unassigned", 1'b0, pts[5]);
        wr(OFF_CTRL, 32'h0);
        set_ready(1'b0);
        chkw("points after drop", 64'h0, pts);
        settle();
        chkw("no evaluation while down", 64'h0, pts);
        rdchk("status down", OFF_STATUS, 32'h0);
        set_ready(1'b1);
        settle();
        rdchk("status up", OFF_STATUS, 32'h3);
        chk1("word limits captured", 1'b1, pts[1]);
        chk1("point 0 back", 1'b1, pts[0]);
        wr(OFF_CTRL, 32'h1);
        wr(12'h030, 32'h2);
        set_ready(1'b0);
        chk1("held point", 1'b1, pts[0]);
        chk1("relay point off", 1'b0, pts[1]);
        stop_test();
    end
endmodule // lsw_bench
